// ===== rtl/external_access_strobe_ctl.sv
// Behaviour
// RULE1 - the address latch strobe is high only during an external cycle, never for internal accesses.
// RULE2 - the latch strobe rises at the start of each external cycle while the address is on the bus.
// RULE3 - partition accesses go internal when the latched strap is high and external when low.
// RULE4 - accesses outside the partition are routed without regard to the strap.
// RULE5 - the strap is sampled only at reset release and later changes are ignored.
// RULE6 - a programming-level strap at reset release selects programming mode; the board supplies it.
// RULE7 - the active-low address valid output stays low for the whole external cycle and rises at its end.
// RULE8 - the address goes out on the muxed lines first, then 8- or 16-bit data moves on them.
// RULE9 - the shared pin is latch strobe, address valid or a port bit, as configured.
`timescale 1ns/1ps
module external_access_strobe_ctl
	import ext_access_pkg::*;
#(
	parameter logic [ADDR_W-1:0] PART_LOW = PART_LO,
	parameter logic [ADDR_W-1:0] PART_HIGH = PART_HI
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic external_access_strap_n,
	input wire logic strapProgLevel,
	input wire logic [1:0] pinMode,
	input wire logic port5_bit0,
	input wire logic extMemAll,
	input wire mem_req_t req,
	output mem_rsp_t rsp,
	output logic reqReady,
	output logic progMode,
	input wire logic [DATA_W-1:0] busIn,
	output logic [DATA_W-1:0] muxed_addr_data_bus,
	output logic [DATA_W-1:0] busOe,
	output logic sharedPin,
	output logic [DATA_W-1:0] intAddr,
	output logic intStrobe
);
	bus_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	mem_req_t cur_r, cur_nxt;
	mem_rsp_t rsp_r, rsp_nxt;
	logic [DATA_W-1:0] bus_r, bus_nxt;
	logic [DATA_W-1:0] oe_r, oe_nxt;
	logic pin_r, pin_nxt;
	logic ready_r, ready_nxt;
	logic [DATA_W-1:0] iaddr_r, iaddr_nxt;
	logic istb_r, istb_nxt;
	logic armed_r, armed_nxt;
	logic strapHigh;
	logic progLatched;
	logic inPart;
	logic goExt;
	logic latchOn, validOn;

	strap_latch u_strap
	(
		.clock(clock),
		.rst(rst),
		.strapLevel(external_access_strap_n),
		.strapProgLevel(strapProgLevel),
		.strapHigh(strapHigh),
		.progMode(progLatched)
	);

	always_comb
	begin
		inPart = (req.addr >= PART_LOW) && (req.addr <= PART_HIGH);
		if (inPart)
			goExt = ~strapHigh; // [RULE3]
		else
			goExt = extMemAll; // [RULE4]
	end

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		cur_nxt = cur_r;
		rsp_nxt = rsp_r;
		rsp_nxt.done = 1'b0;
		bus_nxt = bus_r;
		oe_nxt = oe_r;
		ready_nxt = ready_r;
		iaddr_nxt = iaddr_r;
		istb_nxt = 1'b0;
		armed_nxt = 1'b1;
		latchOn = 1'b0;
		validOn = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				oe_nxt = '0;
				// ready waits one clock so the strap and programming level are latched first
				ready_nxt = armed_r && !progLatched; // [RULE6]
				if (req.valid && ready_r && !progLatched)
				begin
					cur_nxt = req;
					ready_nxt = 1'b0;
					if (goExt)
					begin
						state_nxt = ST_ADDR;
						cnt_nxt = ADDR_CYCLES;
						bus_nxt = req.addr; // [RULE8]
						oe_nxt = '1;
						// strobe and address leave the flops on the same edge
						latchOn = 1'b1; // [RULE2]
						validOn = 1'b1; // [RULE7]
					end
					else
					begin
						iaddr_nxt = req.addr;
						istb_nxt = 1'b1;
						state_nxt = ST_DONE;
						rsp_nxt.external = 1'b0;
						rsp_nxt.rdata = busIn;
					end
				end
			end
			ST_ADDR:
			begin
				validOn = 1'b1;
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1)
				begin
					state_nxt = ST_DATA;
					cnt_nxt = DATA_CYCLES;
					bus_nxt = cur_r.wdata;
					// narrow writes drive only the low byte
					oe_nxt = cur_r.write ? (cur_r.wide ? 16'hFFFF : 16'h00FF) : 16'h0000; // [RULE8]
				end
			end
			ST_DATA:
			begin
				validOn = 1'b1; // [RULE7]
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1)
				begin
					state_nxt = ST_DONE;
					oe_nxt = '0;
					rsp_nxt.external = 1'b1;
					rsp_nxt.rdata = cur_r.wide ? busIn : {8'h00, busIn[7:0]};
				end
			end
			ST_DONE:
			begin
				rsp_nxt.done = 1'b1;
				ready_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
		// shared pin: strobe, address valid or port bit
		case (pinMode)
			PIN_LATCH: pin_nxt = latchOn; // [RULE1] [RULE9]
			PIN_VALID: pin_nxt = ~(validOn && state_nxt != ST_DONE); // [RULE7] [RULE9]
			default: pin_nxt = port5_bit0; // [RULE9]
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			cur_r <= '0;
			rsp_r <= '0;
			bus_r <= '0;
			oe_r <= '0;
			pin_r <= 1'b0;
			ready_r <= 1'b0;
			iaddr_r <= '0;
			istb_r <= 1'b0;
			armed_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			cur_r <= cur_nxt;
			rsp_r <= rsp_nxt;
			bus_r <= bus_nxt;
			oe_r <= oe_nxt;
			pin_r <= pin_nxt;
			ready_r <= ready_nxt;
			iaddr_r <= iaddr_nxt;
			istb_r <= istb_nxt;
			armed_r <= armed_nxt;
		end
	end

	assign rsp = rsp_r;
	assign reqReady = ready_r;
	assign progMode = progLatched; // [RULE6]
	assign muxed_addr_data_bus = bus_r;
	assign busOe = oe_r;
	assign sharedPin = pin_r;
	assign intAddr = iaddr_r;
	assign intStrobe = istb_r;
endmodule : external_access_strobe_ctl

// ===== rtl/ext_access_pkg.sv
package ext_access_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// partition covering special-purpose and program memory (bounds are plain defaults)
	localparam logic [ADDR_W-1:0] PART_LO = 16'h2000;
	localparam logic [ADDR_W-1:0] PART_HI = 16'h7FFF;
	// external bus timing in core clocks
	localparam logic [3:0] ADDR_CYCLES = 4'h1;
	localparam logic [3:0] DATA_CYCLES = 4'h2;
	localparam logic [1:0] PIN_PORT = 2'h0;
	localparam logic [1:0] PIN_LATCH = 2'h1;
	localparam logic [1:0] PIN_VALID = 2'h2;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_DONE = 2'b11
	} bus_state_t;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic wide;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mem_req_t;

	typedef struct packed
	{
		logic done;
		logic external;
		logic [DATA_W-1:0] rdata;
	} mem_rsp_t;
endpackage : ext_access_pkg

// ===== rtl/strap_latch.sv
`timescale 1ns/1ps
module strap_latch
	import ext_access_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic strapLevel,
	input wire logic strapProgLevel,
	output logic strapHigh,
	output logic progMode
);
	logic rstSeen_r, rstSeen_nxt;
	logic strapHigh_r, strapHigh_nxt;
	logic progMode_r, progMode_nxt;

	always_comb
	begin
		rstSeen_nxt = 1'b0;
		strapHigh_nxt = strapHigh_r;
		progMode_nxt = progMode_r;
		// capture only on the first clock after reset release
		if (rstSeen_r)
		begin
			strapHigh_nxt = strapLevel; // [RULE5]
			progMode_nxt = strapProgLevel; // [RULE6]
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rstSeen_r <= 1'b1;
			strapHigh_r <= 1'b1;
			progMode_r <= 1'b0;
		end
		else
		begin
			rstSeen_r <= rstSeen_nxt;
			strapHigh_r <= strapHigh_nxt;
			progMode_r <= progMode_nxt;
		end
	end

	assign strapHigh = strapHigh_r;
	assign progMode = progMode_r;
endmodule : strap_latch

// ===== testbench/ext_access_monitor.sv
`timescale 1ns/1ps
module ext_access_monitor
	import ext_access_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] pinMode,
	input wire logic port5_bit0,
	input wire mem_req_t req,
	input wire mem_rsp_t rsp,
	input wire logic reqReady,
	input wire logic progMode,
	input wire logic [15:0] muxed_addr_data_bus,
	input wire logic [15:0] busOe,
	input wire logic sharedPin,
	input wire logic intStrobe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire lat = pinMode == PIN_LATCH && sharedPin;
	sequence s_advLow;
		pinMode == PIN_VALID && $fell(sharedPin);
	endsequence
	property p_lat; lat |-> busOe == 16'hFFFF; endproperty
	a_lat: assert property (p_lat) else $error("strobe");
	property p_adr; lat |-> muxed_addr_data_bus == req.addr; endproperty
	a_adr: assert property (p_adr) else $error("address");
	property p_pulse; lat |=> !sharedPin; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_adv; s_advLow |-> !sharedPin [*3] ##1 sharedPin; endproperty
	a_adv: assert property (p_adv) else $error("valid");
	property p_int; intStrobe |-> busOe == 16'h0000 && !lat; endproperty
	a_int: assert property (p_int) else $error("internal");
	property p_ext; rsp.done && rsp.external |-> $past(busOe, 4) == 16'hFFFF; endproperty
	a_ext: assert property (p_ext) else $error("external");
	property p_ans; req.valid && reqReady |-> ##[1:7] rsp.done; endproperty
	a_ans: assert property (p_ans) else $error("answer");
	property p_prog; progMode |-> !reqReady && busOe == 16'h0000; endproperty
	a_prog: assert property (p_prog) else $error("program");
	property p_port; pinMode == PIN_PORT && !rst |=> sharedPin == $past(port5_bit0); endproperty
	a_port: assert property (p_port) else $error("port");
endmodule : ext_access_monitor
bind external_access_strobe_ctl ext_access_monitor mon (.*);

// ===== testbench/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model
(
	input wire logic clock,
	input wire logic latchStb,
	input wire logic [15:0] muxed_addr_data_bus,
	input wire logic [15:0] busOe,
	output logic [15:0] busIn = 16'h5A5A
);
	logic [15:0] addr_r = 16'h0000;
	logic [2:0] ph_r = 3'h0;
	always @(posedge clock)
	begin
		ph_r <= {ph_r[1:0], latchStb};
		if (latchStb)
			addr_r <= muxed_addr_data_bus;
		// content is the inverted address; a driven or idle bus keeps toggling
		busIn <= (|ph_r[1:0] && busOe == 16'h0000) ? ~addr_r : ~busIn;
	end
endmodule : ext_mem_model

// ===== testbench/external_access_strobe_ctl_tb_top.sv
`timescale 1ns/1ps
module external_access_strobe_ctl_tb_top
	import ext_access_pkg::*;
;
	logic clock = 1'h0, rst = 1'h1, external_access_strap_n = 1'h0, strapProgLevel = 1'h0;
	logic port5_bit0 = 1'h0, extMemAll = 1'h0, reqReady, progMode, sharedPin, intStrobe, seen, got;
	logic [1:0] pinMode = PIN_LATCH;
	logic [15:0] busIn, muxed_addr_data_bus, busOe, bd, intAddr;
	mem_req_t req = '0;
	mem_rsp_t rsp;
	int n_mismatch = 0, total_checks = 0, n;
	typedef struct packed {logic [15:0] a; logic w, wd, all, ext; logic [15:0] d;} row_t;
	row_t rows [4] = '{'{16'h2000, 1'h0, 1'h1, 1'h0, 1'h1, 16'hDFFF}, '{16'h1FFF, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0000},
		'{16'h8001, 1'h0, 1'h0, 1'h1, 1'h1, 16'h00FE}, '{16'h4000, 1'h1, 1'h1, 1'h0, 1'h1, 16'hC3A5}};
	always #25 clock = ~clock;
	external_access_strobe_ctl DUT (.*);
	ext_mem_model mem (.*, .latchStb(sharedPin && pinMode == PIN_LATCH));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seenV);
		total_checks++;
		if (seenV !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seenV);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic reboot(input logic s, input logic p);
		rst <= 1'h1;
		external_access_strap_n <= s;
		strapProgLevel <= p;
		repeat (10) @(posedge clock);
		rst <= 1'h0;
		repeat (2) @(posedge clock);
	endtask : reboot
	task automatic xfer(input logic [15:0] a, input logic w, input logic wd);
		req <= '{1'h1, w, wd, a, 16'hC3A5};
		n = 0;
		seen = 1'h0;
		@(posedge clock);
		req.valid <= 1'h0;
		while (rsp.done !== 1'h1 && n < 12)
		begin
			@(posedge clock);
			n++;
			if (seen)
				bd = muxed_addr_data_bus;
			seen = sharedPin && pinMode == PIN_LATCH;
		end
		got = rsp.done;
	endtask : xfer
	initial
	begin
		repeat (2000) @(posedge clock);
		n_mismatch++;
		give_verdict();
	end
	initial
	begin
		reboot(1'h0, 1'h0);
		foreach (rows[i])
		begin
			extMemAll <= rows[i].all;
			xfer(rows[i].a, rows[i].w, rows[i].wd);
			chk("answer", 16'h0001, {15'h0, got});
			chk("external", {15'h0, rows[i].ext}, {15'h0, rsp.external});
			if (rows[i].ext)
				chk("data", rows[i].d, rows[i].w ? bd : rsp.rdata);
			else
				chk("internal addr", rows[i].a, intAddr);
		end
		// strap moved after release must not reroute
		external_access_strap_n <= 1'h1;
		xfer(16'h2000, 1'h0, 1'h1);
		chk("strap hold", 16'h0001, {15'h0, rsp.external});
		reboot(1'h1, 1'h0);
		xfer(16'h2000, 1'h0, 1'h1);
		chk("strap high", 16'h0000, {15'h0, rsp.external});
		pinMode <= PIN_VALID;
		extMemAll <= 1'h1;
		xfer(16'h9000, 1'h0, 1'h1);
		chk("valid cycle", 16'h0001, {15'h0, rsp.external});
		pinMode <= PIN_PORT;
		port5_bit0 <= 1'h1;
		repeat (2) @(posedge clock);
		chk("port pin", 16'h0001, {15'h0, sharedPin});
		pinMode <= 2'h3;
		port5_bit0 <= 1'h0;
		repeat (2) @(posedge clock);
		chk("spare mode pin", 16'h0000, {15'h0, sharedPin});
		reboot(1'h1, 1'h1);
		xfer(16'h2000, 1'h0, 1'h1);
		chk("refused", 16'h0002, {14'h0, progMode, got});
		give_verdict();
	end
endmodule : external_access_strobe_ctl_tb_top
